//--- tb.sv
// Self-checking bench for the Type-C port power manager.
// Assumes the sink model on the CC side and a short debounce count.
`timescale 1ns/1ps
module tb;
    import tcpm_pkg::*;
    localparam int DB = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic aux = 1'b0, en = 1'b0, lvl = 1'b0, hi = 1'b0, draw = 1'b0;
    logic [1:0] sink = 2'h0, cab = 2'h0;
    tcpm_cc_s cc;
    tcpm_pwr_s pwr;
    tcpm_adv_e adv;
    logic over, ai, ai_oe, ld, ld_oe, mon;
    logic [9:0] obs;
    logic [9:0] exp_q[$];
    event ev;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    assign obs = {pwr, adv, ai_oe, ai, ld_oe, ld, mon};
    always #5 clk = ~clk;
    tcpm_top #(.DEBOUNCE_CNT(DB)) dut (.core_clk_in(clk), .reset_in(rst),
        .aux_good_in(aux), .enable_in(en), .adv_level_sel_in(lvl), .adv_high_sel_in(hi),
        .cc_in(cc), .over_threshold_in(over), .pwr_out(pwr), .adv_level_out(adv),
        .attach_indicator_n_out(ai), .attach_indicator_n_oe_out(ai_oe),
        .load_detect_n_out(ld), .load_detect_n_oe_out(ld_oe), .cc_monitor_on_out(mon));
    tcpm_sink_model u_sink (.core_clk_in(clk), .sink_in(sink), .cable_in(cab),
        .draw_high_in(draw), .adv_in(adv), .charge_on_in(pwr.charge_on),
        .cc_out(cc), .over_threshold_out(over));
    // ------------------------------------------------------------------
    // Expectation queue and checking
    // ------------------------------------------------------------------
    function automatic logic [9:0] mk(logic [2:0] p, tcpm_adv_e a, logic i, logic l, logic m);
        return {p, a, i, 1'b0, l, 1'b0, m};
    endfunction
    function automatic tcpm_adv_e ea(logic l, logic h);
        return !l ? TCPM_ADV_DEFAULT : (h ? TCPM_ADV_HIGH : TCPM_ADV_MEDIUM);
    endfunction
    task automatic check(logic [9:0] seen, logic [9:0] want);
        n_checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("ERROR outputs expected %h seen %h", want, seen);
        end
    endtask
    task automatic note(logic [9:0] e);
        exp_q.push_back(e);
        ->ev;
    endtask
    task automatic settle(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_chg();
        for (int k = 0; k < 4 * DB + 20 && pwr.charge_on !== 1'b1; k++)
            @(negedge clk);
        @(negedge clk);
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(ev)
    begin
        while (exp_q.size() > 0)
            check(obs, exp_q.pop_front());
    end
    // A hang counts as a failure rather than running forever.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    initial
    begin
        void'($urandom(32'hE9A0));
        settle(6);
        note(mk(3'h0, TCPM_ADV_DEFAULT, 0, 0, 0));
        rst <= 1'b0;
        en <= 1'b1;
        settle(3);
        note(mk(3'h0, TCPM_ADV_DEFAULT, 0, 0, 0));
        aux <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            {lvl, hi} <= (i < 4) ? 2'(i) : 2'($urandom);
            settle(3);
            note(mk(3'h0, ea(lvl, hi), 0, 0, 1));
        end
        {lvl, hi} <= 2'h3;
        sink <= 2'h3;
        settle(3 * DB);
        note(mk(3'h0, TCPM_ADV_HIGH, 0, 0, 1));
        sink <= 2'h2;
        cab <= 2'h1;
        settle(4);
        note(mk(3'h0, TCPM_ADV_HIGH, 0, 0, 1));
        wait_chg();
        note(mk(3'h5, TCPM_ADV_HIGH, 1, 0, 1));
        draw <= 1'b1;
        settle(5);
        note(mk(3'h5, TCPM_ADV_HIGH, 1, 1, 1));
        hi <= 1'b0;
        settle(10);
        note(mk(3'h5, TCPM_ADV_MEDIUM, 1, 0, 1));
        hi <= 1'b1;
        settle(9);
        note(mk(3'h5, TCPM_ADV_HIGH, 1, 1, 1));
        draw <= 1'b0;
        settle(5);
        note(mk(3'h5, TCPM_ADV_HIGH, 1, 0, 1));
        sink <= 2'h0;
        settle(4);
        note(mk(3'h0, TCPM_ADV_HIGH, 0, 0, 1));
        sink <= 2'h1;
        cab <= 2'h2;
        wait_chg();
        note(mk(3'h6, TCPM_ADV_HIGH, 1, 0, 1));
        lvl <= 1'b0;
        en <= 1'b0;
        settle(3);
        note(mk(3'h0, TCPM_ADV_DEFAULT, 0, 0, 0));
        finish_test();
    end
endmodule // tb

//--- tcpm_assertions.sv
// Checker for the ports of the Type-C port power manager.
// Assumes it is bound to tcpm_top and shares its DEBOUNCE_CNT value.
`timescale 1ns/1ps
module tcpm_assertions
    import tcpm_pkg::*;
#(
    parameter int DEBOUNCE_CNT = 8
)
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic aux_good_in,
    input wire logic enable_in,
    input wire logic adv_level_sel_in,
    input wire logic adv_high_sel_in,
    input wire tcpm_cc_s cc_in,
    input wire logic over_threshold_in,
    input wire tcpm_pwr_s pwr_out,
    input wire tcpm_adv_e adv_level_out,
    input wire logic attach_indicator_n_oe_out,
    input wire logic load_detect_n_oe_out,
    input wire logic cc_monitor_on_out
);
    // ------------------------------------------------------------------
    // Input history counters
    // ------------------------------------------------------------------
    logic [3:0] run_q, run_d, off_q, off_d;
    // The attach history is as wide as the design's counter, so that the full
    // default debounce fits without saturating below it.
    logic [CNT_W-1:0] att_q, att_d;
    logic cc1_q, cc1_d;
    logic run;
    assign run = aux_good_in && enable_in;
    always_comb
    begin
        run_d = run ? run_q + {3'h0, run_q != 4'hF} : 4'h0;
        off_d = run ? 4'h0 : off_q + {3'h0, off_q != 4'hF};
        cc1_d = cc_in.cc1_sink;
        att_d = ((cc_in.cc1_sink ^ cc_in.cc2_sink) && cc1_d == cc1_q) ?
            att_q + {{(CNT_W-1){1'b0}}, att_q != '1} : CNT_ZERO;
    end
    always_ff @(posedge core_clk_in)
    begin
        run_q <= reset_in ? 4'h0 : run_d;
        off_q <= reset_in ? 4'h0 : off_d;
        att_q <= reset_in ? CNT_ZERO : att_d;
        cc1_q <= cc1_d;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_chg_rise;
        $rose(pwr_out.charge_on);
    endsequence
    a_disabled_all_off: assert property (off_q > 4'h3 |-> pwr_out == 3'h0 &&
        !attach_indicator_n_oe_out && !load_detect_n_oe_out && !cc_monitor_on_out)
        else $error("outputs active while disabled");
    a_run_monitors_cc: assert property (run_q > 4'h3 |-> cc_monitor_on_out)
        else $error("cc monitor off while running");
    a_adv_high_level: assert property (run_q > 4'h3 && $past(adv_level_sel_in, 3) &&
        $past(adv_high_sel_in, 3) |-> adv_level_out == TCPM_ADV_HIGH)
        else $error("high level not advertised");
    a_adv_medium_level: assert property (run_q > 4'h3 && $past(adv_level_sel_in, 3) &&
        !$past(adv_high_sel_in, 3) |-> adv_level_out == TCPM_ADV_MEDIUM)
        else $error("medium level not advertised");
    a_load_has_cause: assert property (load_detect_n_oe_out |-> $past(over_threshold_in, 3))
        else $error("load detect without over threshold");
    a_load_high_only: assert property (load_detect_n_oe_out &&
        adv_level_out != TCPM_ADV_HIGH |=> !load_detect_n_oe_out)
        else $error("load detect outside high level");
    a_charge_debounced: assert property (s_chg_rise |-> att_q >= DEBOUNCE_CNT)
        else $error("charge switch on before debounce");
    a_bus_needs_sink: assert property (pwr_out.charge_on |->
        $past(cc_in.cc1_sink ^ cc_in.cc2_sink, 3))
        else $error("bus power without attach");
    a_vconn_free_line: assert property (pwr_out.vconn_cc2_on |->
        $past(cc_in.cc2_cable && !cc_in.cc2_sink, 3))
        else $error("cable power on wrong line");
    a_vconn_cc1_line: assert property (pwr_out.vconn_cc1_on |->
        $past(cc_in.cc1_cable && !cc_in.cc1_sink, 3))
        else $error("cable power on cc1 without cable load");
    a_ind_with_charge: assert property (s_chg_rise |-> ##[0:1] attach_indicator_n_oe_out)
        else $error("attach indicator not pulled low");
endmodule // tcpm_assertions

bind tcpm_top tcpm_assertions #(.DEBOUNCE_CNT(DEBOUNCE_CNT)) u_chk (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .aux_good_in(aux_good_in),
    .enable_in(enable_in), .adv_level_sel_in(adv_level_sel_in),
    .adv_high_sel_in(adv_high_sel_in), .cc_in(cc_in), .over_threshold_in(over_threshold_in),
    .pwr_out(pwr_out), .adv_level_out(adv_level_out),
    .attach_indicator_n_oe_out(attach_indicator_n_oe_out),
    .load_detect_n_oe_out(load_detect_n_oe_out), .cc_monitor_on_out(cc_monitor_on_out));

//--- tcpm_pkg.sv
// Package for the Type-C downstream port attach and power manager.
// Assumes a single 100 MHz clock and analog comparators outside the logic.
package tcpm_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEBOUNCE_MS = 150;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

    // ------------------------------------------------------------------
    // Advertisement levels on CC
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TCPM_ADV_DEFAULT,
        TCPM_ADV_MEDIUM,
        TCPM_ADV_HIGH
    } tcpm_adv_e;

    // Controller states.
    typedef enum logic [1:0] {
        TCPM_ST_OFF,
        TCPM_ST_UNATTACHED,
        TCPM_ST_DEBOUNCE,
        TCPM_ST_ATTACHED
    } tcpm_state_e;

    // Comparator results for both CC lines.
    typedef struct packed {
        logic cc1_sink;
        logic cc2_sink;
        logic cc1_cable;
        logic cc2_cable;
    } tcpm_cc_s;

    // Power switch controls.
    typedef struct packed {
        logic charge_on;
        logic vconn_cc1_on;
        logic vconn_cc2_on;
    } tcpm_pwr_s;

    // Attach condition: exactly one CC line sees a sink termination.
    function automatic logic tcpm_sink_seen(input tcpm_cc_s cc);
        return cc.cc1_sink ^ cc.cc2_sink;
    endfunction

endpackage

//--- tcpm_sink_model.sv
// Behavioural attached sink: line terminations and charging load.
// Assumes the bench sets terminations and wanted load at the falling edge.
`timescale 1ns/1ps
module tcpm_sink_model
    import tcpm_pkg::*;
#(
    parameter int ADAPT = 5
)
(
    input wire logic core_clk_in,
    input wire logic [1:0] sink_in,
    input wire logic [1:0] cable_in,
    input wire logic draw_high_in,
    input wire tcpm_adv_e adv_in,
    input wire logic charge_on_in,
    output tcpm_cc_s cc_out,
    output logic over_threshold_out
);
    int lag = 0;
    assign cc_out = {sink_in, cable_in};
    initial over_threshold_out = 1'b0;
    // load cut after drop
    // The load is shed some cycles late on purpose, as a real sink would.
    always @(negedge core_clk_in)
    begin
        lag <= (adv_in == TCPM_ADV_HIGH) ? 0 : lag + 1;
        over_threshold_out <= draw_high_in && charge_on_in && lag < ADAPT;
    end
endmodule // tcpm_sink_model

//--- tcpm_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes the inputs are quasi-static comparator and pin levels.
`timescale 1ns/1ps
module tcpm_sync #(
    parameter int WIDTH = 1
)
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // tcpm_sync

//--- tcpm_top.sv
// Attach detection, power switch control, current advertisement and load
// detection for one downstream-facing Type-C port.
// Assumes analog comparators, an aux supply monitor and the enable pin
// arrive asynchronously; open-drain outputs are pulled up outside.
//
// Overview of operation
// RULE1: Pull attach indicator low while attached.
// RULE2: Release attach indicator while unattached.
// RULE3: Load detect low only when current over threshold.
// RULE4: Release load detect when current drops again.
// RULE5: High select low gives medium advertisement.
// RULE6: Both selects high give high advertisement.
// RULE7: Sink adapts current within 60 ms.
// RULE8: Sample enable only after aux supply good.
// RULE9: Enable high starts operation, else disabled.
// RULE10: After start-up watch both CC lines.
// RULE11: Charge switch on after attach debounce.
// RULE12: Cable power onto line seeing cable load.
// RULE13: Bus power only while attached.
// RULE14: Advertisement chosen by two select inputs.
// RULE15: Load detect only at high advertisement.
// RULE16: Enable low opens switches, releases outputs.
// RULE17: Debounce counted, restarts on attach change.
// RULE18: Comparator results arrive synchronised.
`timescale 1ns/1ps
module tcpm_top
    import tcpm_pkg::*;
#(
    parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES
)
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic aux_good_in,
    input wire logic enable_in,
    input wire logic adv_level_sel_in,
    input wire logic adv_high_sel_in,
    input wire tcpm_cc_s cc_in,
    input wire logic over_threshold_in,
    output tcpm_pwr_s pwr_out,
    output tcpm_adv_e adv_level_out,
    output logic attach_indicator_n_out,
    output logic attach_indicator_n_oe_out,
    output logic load_detect_n_out,
    output logic load_detect_n_oe_out,
    output logic cc_monitor_on_out
);
    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    localparam int SYNC_W = 9;
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] raw_sync;
    tcpm_cc_s cc_s;
    logic aux_good_s;
    logic enable_s;
    logic sel_level_s;
    logic sel_high_s;
    logic over_s;

    assign raw_in = {aux_good_in, enable_in, adv_level_sel_in, adv_high_sel_in,
                     cc_in, over_threshold_in};

    // RULE18: comparators synchronised
    tcpm_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .async_in(raw_in),
        .sync_out(raw_sync)
    );

    assign {aux_good_s, enable_s, sel_level_s, sel_high_s, cc_s, over_s} = raw_sync;

    // ------------------------------------------------------------------
    // Attach state machine
    // ------------------------------------------------------------------
    tcpm_state_e state_q;
    tcpm_state_e state_d;
    logic [CNT_W-1:0] deb_cnt_q;
    logic [CNT_W-1:0] deb_cnt_d;
    logic sink_cc1_q;
    logic sink_cc1_d;
    logic attach_now;
    logic running;

    // RULE8: enable only counts once aux is good
    assign running = aux_good_s && enable_s;
    assign attach_now = tcpm_sink_seen(cc_s);

    // A flip of orientation means a new plug, so it counts as losing the attach.
    // This keeps the debounce and the cable power tied to one plug orientation.
    function automatic logic attach_held(input tcpm_cc_s cc, input logic cc1_latched);
        return tcpm_sink_seen(cc) && (cc.cc1_sink == cc1_latched);
    endfunction

    always_comb
    begin
        state_d = state_q;
        deb_cnt_d = deb_cnt_q;
        sink_cc1_d = sink_cc1_q;
        case (state_q)
            TCPM_ST_OFF:
            begin
                deb_cnt_d = CNT_ZERO;
                // RULE9: leave start-up on enable high
                if (running)
                begin
                    state_d = TCPM_ST_UNATTACHED;
                end
            end
            TCPM_ST_UNATTACHED:
            begin
                deb_cnt_d = CNT_ZERO;
                // RULE10: watch both CC lines
                if (attach_now)
                begin
                    state_d = TCPM_ST_DEBOUNCE;
                    sink_cc1_d = cc_s.cc1_sink;
                end
            end
            TCPM_ST_DEBOUNCE:
            begin
                // RULE17: restart when the attach condition changes
                if (!attach_held(cc_s, sink_cc1_q))
                begin
                    state_d = TCPM_ST_UNATTACHED;
                    deb_cnt_d = CNT_ZERO;
                end
                // RULE11: switch only after debounce elapsed
                else if (deb_cnt_q >= DEBOUNCE_CNT[CNT_W-1:0] - CNT_ONE)
                begin
                    state_d = TCPM_ST_ATTACHED;
                end
                else
                begin
                    deb_cnt_d = deb_cnt_q + CNT_ONE;
                end
            end
            TCPM_ST_ATTACHED:
            begin
                // RULE13: detach removes bus power at once
                if (!attach_held(cc_s, sink_cc1_q))
                begin
                    state_d = TCPM_ST_UNATTACHED;
                    deb_cnt_d = CNT_ZERO;
                end
            end
            default:
            begin
                state_d = TCPM_ST_OFF;
            end
        endcase
        // RULE16: enable low forces the disabled state
        if (!running)
        begin
            state_d = TCPM_ST_OFF;
            deb_cnt_d = CNT_ZERO;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            state_q <= TCPM_ST_OFF;
            deb_cnt_q <= CNT_ZERO;
            sink_cc1_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            deb_cnt_q <= deb_cnt_d;
            sink_cc1_q <= sink_cc1_d;
        end
    end

    // ------------------------------------------------------------------
    // Power switch registers
    // ------------------------------------------------------------------
    tcpm_pwr_s pwr_q;
    tcpm_pwr_s pwr_d;
    logic attached_next;

    // Outputs follow the next state so they change with it, not a cycle later.
    assign attached_next = (state_d == TCPM_ST_ATTACHED);

    always_comb
    begin
        pwr_d = '0;
        // RULE13: bus power only while attached
        // RULE11: charge switch after debounce
        pwr_d.charge_on = attached_next;
        // RULE12: cable power on the line not used by the sink
        // The two enables take sink_cc1_d in opposite sense, so they never meet.
        pwr_d.vconn_cc1_on = attached_next && !sink_cc1_d && cc_s.cc1_cable;
        pwr_d.vconn_cc2_on = attached_next && sink_cc1_d && cc_s.cc2_cable;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            pwr_q <= '0;
        end
        else
        begin
            pwr_q <= pwr_d;
        end
    end

    // ------------------------------------------------------------------
    // Current advertisement
    // ------------------------------------------------------------------
    tcpm_adv_e adv_q;
    tcpm_adv_e adv_d;

    // With power sharing the other port's load detect drives the high
    // select, so a drop to medium here answers a heavy load over there.
    always_comb
    begin
        // RULE14: advertisement from the two selects
        // RULE6: both high advertise high
        // RULE5: high select low drops to medium
        if (sel_level_s && sel_high_s)
        begin
            adv_d = TCPM_ADV_HIGH;
        end
        else if (sel_level_s)
        begin
            adv_d = TCPM_ADV_MEDIUM;
        end
        else
        begin
            adv_d = TCPM_ADV_DEFAULT;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            adv_q <= TCPM_ADV_DEFAULT;
        end
        else
        begin
            adv_q <= adv_d;
        end
    end

    // ------------------------------------------------------------------
    // Open-drain indicators and CC monitor
    // ------------------------------------------------------------------
    logic att_oe_q;
    logic att_oe_d;
    logic ld_oe_q;
    logic ld_oe_d;
    logic mon_q;
    logic mon_d;

    always_comb
    begin
        // RULE1: attach indicator pulled low while attached
        // RULE2: released otherwise
        att_oe_d = attached_next;

        // Load detect falls with the attach, so a stale threshold level cannot
        // keep the other port at the medium level after an unplug.
        // RULE3: assert only above threshold while attached
        // RULE4: release when current falls
        // RULE15: only at the high advertisement
        ld_oe_d = attached_next && over_s && (adv_d == TCPM_ADV_HIGH);

        // RULE16: CC monitor off while disabled
        mon_d = (state_d != TCPM_ST_OFF);
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            att_oe_q <= 1'b0;
            ld_oe_q <= 1'b0;
            mon_q <= 1'b0;
        end
        else
        begin
            att_oe_q <= att_oe_d;
            ld_oe_q <= ld_oe_d;
            mon_q <= mon_d;
        end
    end

    // Open-drain pins: data is constant low, only the enable moves.
    assign pwr_out = pwr_q;
    assign adv_level_out = adv_q;
    assign attach_indicator_n_out = 1'b0;
    assign attach_indicator_n_oe_out = att_oe_q;
    assign load_detect_n_out = 1'b0;
    assign load_detect_n_oe_out = ld_oe_q;
    assign cc_monitor_on_out = mon_q;
endmodule // tcpm_top
